// ### dv/adcr_core_model.sv
// Behavioural converter core
`timescale 1ns/1ps
`default_nettype none
module adcr_core_model
(
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    // Control from the block
    input  wire logic [adcr_pkg::CHAN_W-1:0]  chan_i,
    input  wire logic                         start_i,
    input  wire logic                         pwr_i,
    // Result to the block
    output logic [adcr_pkg::RES_W-1:0]        result_o
);
    import adcr_pkg::*;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            result_o <= 10'h155;
        end else if (start_i) begin
            result_o <= {chan_i, ~chan_i};
        end else if (!pwr_i) begin
            // Powered off: no stable value
            result_o <= ~result_o;
        end
    end
endmodule
`default_nettype wire

// ### dv/adcr_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adcr_pkg::*;
    localparam logic [4:0] CH [8] = '{5'h00, 5'h09, 5'h1d, 5'h1e, 5'h01, 5'h02, 5'h07, 5'h08};
    logic              clk_i;
    logic              reset_n_i;
    logic              xtal_clk_i;
    adcr_bus_req_t     bus;
    logic [DATA_W-1:0] rdata;
    logic [CHAN_W-1:0] chan;
    logic              pwr, start, busy, tick, fact, irq;
    logic [RES_W-1:0]  res;
    int                errors, samples_checked;

    adcr_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus), .rdata_o(rdata),
        .xtal_clk_i(xtal_clk_i), .channel_select_o(chan), .core_power_en_o(pwr),
        .conv_start_o(start), .conv_busy_o(busy), .adc_tick_o(tick),
        .factory_code_o(fact), .core_result_i(res), .irq_o(irq));
    adcr_core_model u_core (.clk_i(clk_i), .rst_n_i(reset_n_i), .chan_i(chan),
        .start_i(start), .pwr_i(pwr), .result_o(res));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // crystal at 10 MHz, a quarter of the bus clock, the fastest still seen
    initial begin
        xtal_clk_i = 1'b0;
        forever #50 xtal_clk_i = ~xtal_clk_i;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus <= '0;
        #1 v = rdata;
    endtask
    task automatic idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 200) begin
            @(posedge clk_i);
            #1 k++;
        end
        chk(busy, 1'b0);
    endtask
    // Counts start pulses or converter ticks over 64 cycles
    task automatic cnt(input bit sel, output int n);
        n = 0;
        repeat (64) begin
            @(posedge clk_i);
            #1 n += sel ? int'(start) : int'(tick);
        end
    endtask
    function automatic logic [15:0] fmt_exp(input logic [1:0] m, input logic [4:0] c);
        logic [9:0] r;
        r = {c, ~c};
        case (m)
            2'b00: return {8'h00, r[9:2]};
            2'b01: return {6'h00, r};
            2'b10: return {r, 6'h00};
            default: return {~r[9], r[8:0], 6'h00};
        endcase
    endfunction

    task automatic t_reset();
        logic [7:0] v;
        rd(OFS_STATUS_CONTROL, v);
        chk({v, pwr}, {8'h1f, 1'b0});
        rd(OFS_CLOCK_CONFIG, v);
        chk(v, 8'h04);
        rd(8'h44, v);
        chk(v, 8'h00);
        // Read data stand one cycle only
        @(posedge clk_i);
        #1 chk(rdata, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_formats();
        logic [7:0] v, hi, lo;
        // first result after power-off is thrown away
        wr(OFS_STATUS_CONTROL, 8'h00);
        idle();
        for (int i = 0; i < 8; i++) begin
            wr(OFS_CLOCK_CONFIG, 8'h10 | 8'((i % 4) << 2));
            wr(OFS_STATUS_CONTROL, {3'b000, CH[i]});
            chk(chan, CH[i]);
            idle();
            rd(OFS_STATUS_CONTROL, v);
            chk(v[7], 1'b1);
            rd(OFS_RESULT_HIGH, hi);
            rd(OFS_RESULT_LOW, lo);
            chk({hi, lo}, fmt_exp(2'(i % 4), CH[i]));
            rd(OFS_STATUS_CONTROL, v);
            chk(v[7], 1'b0);
        end
        $display("test formats done");
    endtask
    task automatic t_freeze();
        logic [7:0]  hi, lo;
        logic [15:0] e;
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CLOCK_CONFIG, 8'h10 | 8'(m << 2));
            wr(OFS_STATUS_CONTROL, 8'h02);
            idle();
            rd(OFS_RESULT_HIGH, hi);
            wr(OFS_STATUS_CONTROL, 8'h05);
            idle();
            rd(OFS_RESULT_LOW, lo);
            e = fmt_exp(2'(m), (m == 1) ? 5'h02 : 5'h05);
            chk(lo, e[7:0]);
        end
        rd(OFS_RESULT_HIGH, hi);
        rd(OFS_RESULT_LOW, lo);
        chk({hi, lo}, fmt_exp(2'b01, 5'h02));
        $display("test freeze done");
    endtask
    task automatic t_abort();
        logic [7:0] v, hi, lo;
        wr(OFS_STATUS_CONTROL, 8'h03);
        repeat (5) @(posedge clk_i);
        wr(OFS_STATUS_CONTROL, 8'h07);
        repeat (10) @(posedge clk_i);
        rd(OFS_STATUS_CONTROL, v);
        chk(v, 8'h07);
        idle();
        rd(OFS_RESULT_HIGH, hi);
        rd(OFS_RESULT_LOW, lo);
        chk({hi, lo}, fmt_exp(2'b01, 5'h07));
        $display("test abort done");
    endtask
    task automatic t_irq();
        logic [7:0] v;
        wr(OFS_STATUS_CONTROL, 8'h44);
        idle();
        chk(irq, 1'b1);
        repeat (6) @(posedge clk_i);
        rd(OFS_STATUS_CONTROL, v);
        chk({irq, v}, {1'b1, 8'h44});
        rd(OFS_RESULT_LOW, v);
        chk(irq, 1'b0);
        wr(OFS_STATUS_CONTROL, 8'hdf);
        rd(OFS_STATUS_CONTROL, v);
        chk({irq, v}, {1'b0, 8'hdf});
        $display("test irq done");
    endtask
    task automatic t_cont();
        logic [7:0] v;
        int         n;
        wr(OFS_STATUS_CONTROL, 8'h26);
        cnt(1'b1, n);
        chk(n >= 3, 1'b1);
        rd(OFS_STATUS_CONTROL, v);
        chk(v[7], 1'b1);
        rd(OFS_RESULT_LOW, v);
        repeat (40) @(posedge clk_i);
        rd(OFS_STATUS_CONTROL, v);
        chk({v, busy}, {8'h26, 1'b1});
        wr(OFS_STATUS_CONTROL, 8'h1b);
        chk(fact, 1'b1);
        wr(OFS_STATUS_CONTROL, 8'h1f);
        cnt(1'b1, n);
        chk({n[7:0], busy, pwr}, {8'h00, 2'b00});
        $display("test continuous done");
    endtask
    task automatic t_clock();
        int n, e;
        // Keep the core busy in case ticks are gated
        wr(OFS_STATUS_CONTROL, 8'h20);
        for (int c = 0; c < 5; c++) begin
            wr(OFS_CLOCK_CONFIG, 8'(((c == 4) ? 7 : c) << 5) | 8'h14);
            cnt(1'b0, n);
            e = 64 >> ((c == 4) ? 4 : c);
            chk(n >= e - 1 && n <= e + 1, 1'b1);
        end
        wr(OFS_CLOCK_CONFIG, 8'h04);
        cnt(1'b0, n);
        chk(n >= 15 && n <= 17, 1'b1);
        wr(OFS_STATUS_CONTROL, 8'h1f);
        $display("test clock done");
    endtask

    initial begin
        errors = 0;
        samples_checked = 0;
        reset_n_i = 1'b0;
        bus = '0;
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_formats();
        t_freeze();
        t_abort();
        t_irq();
        t_cont();
        t_clock();
        results();
    end
    // Whole run needs well under 3000 cycles
    initial begin
        #1000000;
        errors++;
        results();
    end
endmodule
`default_nettype wire

// ### dv/adcr_top_asserts.sv
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcr_top_asserts
(
    // Clock, reset, register port
    input wire logic                          clk_i,
    input wire logic                          reset_n_i,
    input wire adcr_pkg::adcr_bus_req_t       bus_i,
    // Converter side and interrupt
    input wire logic [adcr_pkg::CHAN_W-1:0]   channel_select_o,
    input wire logic                          core_power_en_o,
    input wire logic                          conv_start_o,
    input wire logic                          conv_busy_o,
    input wire logic                          adc_tick_o,
    input wire logic                          factory_code_o,
    input wire logic                          irq_o
);
    import adcr_pkg::*;
    logic [5:0] ticks_q;
    logic       wr_sc;
    logic       clr;
    assign wr_sc = bus_i.wr && bus_i.addr == OFS_STATUS_CONTROL;
    assign clr = wr_sc || (bus_i.rd && bus_i.addr == OFS_RESULT_LOW);
    // Restart zeroes it, so a stuck counter shows up
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || conv_start_o) begin
            ticks_q <= '0;
        end else if (adc_tick_o && conv_busy_o) begin
            ticks_q <= ticks_q + 6'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_START_ON_WRITE: assert property (wr_sc && bus_i.wdata[4:0] != CHAN_OFF |=> conv_start_o)
        else $error("no start after control write");
    AST_CHAN_WRITE: assert property (wr_sc |=> channel_select_o == $past(bus_i.wdata[4:0]))
        else $error("channel field not stored");
    AST_POWER: assert property (core_power_en_o == (channel_select_o != CHAN_OFF))
        else $error("power enable wrong");
    AST_OFF_NO_START: assert property (!core_power_en_o |-> !conv_start_o && !conv_busy_o)
        else $error("conversion while powered down");
    AST_FACTORY: assert property (factory_code_o == (channel_select_o == CHAN_FACTORY))
        else $error("factory code flag wrong");
    AST_IRQ_CLEAR: assert property (clr && !conv_busy_o |=> !irq_o)
        else $error("interrupt not removed");
    AST_IRQ_HOLD: assert property (irq_o && !clr |=> irq_o)
        else $error("interrupt dropped early");
    AST_CONV_LEN: assert property ($fell(conv_busy_o) && !$past(bus_i.wr) |-> ticks_q inside {[14:17]})
        else $error("conversion length wrong");
    AST_CONV_MAX: assert property (conv_busy_o |-> ticks_q <= 6'd17)
        else $error("conversion too long");
    COV_DONE: cover property ($fell(conv_busy_o));
    COV_IRQ: cover property ($rose(irq_o));
    COV_OFF: cover property ($fell(core_power_en_o));
endmodule
bind adcr_top adcr_top_asserts u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_i),
    .channel_select_o(channel_select_o), .core_power_en_o(core_power_en_o),
    .conv_start_o(conv_start_o), .conv_busy_o(conv_busy_o), .adc_tick_o(adc_tick_o),
    .factory_code_o(factory_code_o), .irq_o(irq_o));
`default_nettype wire

// ### src/adcr_pkg.sv
// Shared constants and types for the converter control block
package adcr_pkg;

    // Register bus
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } adcr_bus_req_t;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH    = 8'h41;
    localparam logic [ADDR_W-1:0] OFS_RESULT_LOW     = 8'h42;
    localparam logic [ADDR_W-1:0] OFS_CLOCK_CONFIG   = 8'h43;

    // Status/control field positions
    localparam int unsigned SC_DONE_BIT = 7;
    localparam int unsigned SC_IEN_BIT  = 6;
    localparam int unsigned SC_CONT_BIT = 5;
    localparam int unsigned SC_CHAN_LSB = 0;
    localparam int unsigned CHAN_W      = 5;

    // Clock config field positions
    localparam int unsigned CK_DIV_LSB  = 5;
    localparam int unsigned DIV_W       = 3;
    localparam int unsigned CK_ICLK_BIT = 4;
    localparam int unsigned CK_MODE_LSB = 2;
    localparam int unsigned MODE_W      = 2;

    // Reset values
    localparam logic [CHAN_W-1:0] CHAN_RESET  = 5'h1f;
    localparam logic [DIV_W-1:0]  DIV_RESET   = 3'h0;
    localparam logic              ICLK_RESET  = 1'b0;

    // Channel codes
    localparam logic [CHAN_W-1:0] CHAN_EXT_LAST = 5'h09;
    localparam logic [CHAN_W-1:0] CHAN_REF_HIGH = 5'h1d;
    localparam logic [CHAN_W-1:0] CHAN_REF_LOW  = 5'h1e;
    localparam logic [CHAN_W-1:0] CHAN_FACTORY  = 5'h1b;
    localparam logic [CHAN_W-1:0] CHAN_OFF      = 5'h1f;

    // Result formats
    typedef enum logic [1:0] {
        FMT_TRUNC8   = 2'b00,
        FMT_RIGHT    = 2'b01,
        FMT_LEFT     = 2'b10,
        FMT_LEFT_SGN = 2'b11
    } adcr_fmt_t;

    localparam adcr_fmt_t FMT_RESET = FMT_RIGHT;

    // Conversion
    localparam int unsigned RES_W      = 10;
    localparam int unsigned CONV_TICKS = 16;
    localparam int unsigned CNT_W      = 5;
    localparam int unsigned PRE_W      = 4;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } adcr_state_t;

endpackage

// ### src/adcr_top.sv
// Converter control, clock prescaler and result registers
//
// Function
// - Status/control write aborts, restarts conversion
// - Done flag sets per conversion; continuous: once
// - Done clears on control write, low result read
// - Interrupt enabled: done flag plain read/write
// - Interrupt per conversion, cleared by control write, low result read
// - Continuous repeats conversions, else exactly one
// - Five-bit channel field selects input
// - All-ones channel powers converter down
// - Unused codes undefined; factory code forbidden
// - Left format: high holds top eight
// - Left format: low holds two LSBs high
// - Right format: high two MSBs, low eight
// - High read freezes low until read
// - Truncation: low holds top eight, no lock
// - Three-bit prescaler divides 1 to 16
// - Clock select: one bus, zero crystal
// - Format field codes; reset right-justified
// - Signed format inverts result top bit
// - Conversion counts 16 ticks, 15 to 16 tick periods
// - Continuous results overwrite unread results
`timescale 1ns/1ps
`default_nettype none

module adcr_top
(
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          reset_n_i,
    // Register port
    input  wire adcr_pkg::adcr_bus_req_t       bus_i,
    output logic [adcr_pkg::DATA_W-1:0]        rdata_o,
    // External crystal clock, sampled as a pin
    input  wire logic                          xtal_clk_i,
    // Converter core
    output logic [adcr_pkg::CHAN_W-1:0]        channel_select_o,
    output logic                               core_power_en_o,
    output logic                               conv_start_o,
    output logic                               conv_busy_o,
    output logic                               adc_tick_o,
    output logic                               factory_code_o,
    input  wire logic [adcr_pkg::RES_W-1:0]    core_result_i,
    // Interrupt request
    output logic                               irq_o
);
    import adcr_pkg::*;

    // Prescaler mask for a divide code
    function automatic logic [PRE_W-1:0] div_mask(
        input logic [DIV_W-1:0] code
    );
        logic [PRE_W-1:0] m;
        m = 4'hf;
        case (code)
            3'h0: m = 4'h0;
            3'h1: m = 4'h1;
            3'h2: m = 4'h3;
            3'h3: m = 4'h7;
            default: m = 4'hf;
        endcase
        return m;
    endfunction

    // Register address hit
    function automatic logic hit(
        input adcr_bus_req_t   b,
        input logic            strobe,
        input logic [ADDR_W-1:0] ofs
    );
        return strobe && (b.addr == ofs);
    endfunction

    // Register state
    logic                done_q;
    logic                ien_q;
    logic                cont_q;
    logic [CHAN_W-1:0]   chan_q;
    logic [DIV_W-1:0]    div_q;
    logic                iclk_q;
    adcr_fmt_t           fmt_q;
    logic [RES_W-1:0]    res_q;
    logic [DATA_W-1:0]   low_hold_q;
    logic                freeze_q;
    logic                first_q;
    logic                irq_q;
    logic [DATA_W-1:0]   rdata_q;

    // Conversion state
    adcr_state_t         state_q;
    logic [CNT_W-1:0]    tick_cnt_q;
    logic                start_q;
    logic [PRE_W-1:0]    pre_cnt_q;

    // Crystal sampler
    logic                xs1_q;
    logic                xs2_q;
    logic                xs3_q;
    logic                xlvl_q;

    // Decoded accesses
    logic wr_sc;
    logic wr_ck;
    logic rd_hi;
    logic rd_lo;
    logic justified;
    logic in_tick;
    logic adc_tick;
    logic conv_done;
    logic start_now;
    logic [DATA_W-1:0] hi_fmt;
    logic [DATA_W-1:0] lo_fmt;
    logic [DATA_W-1:0] rd_mux;

    assign wr_sc = hit(bus_i, bus_i.wr, OFS_STATUS_CONTROL);
    assign wr_ck = hit(bus_i, bus_i.wr, OFS_CLOCK_CONFIG);
    assign rd_hi = hit(bus_i, bus_i.rd, OFS_RESULT_HIGH);
    assign rd_lo = hit(bus_i, bus_i.rd, OFS_RESULT_LOW);
    assign justified = (fmt_q != FMT_TRUNC8);

    // Crystal pin: three flops, change taken once stages agree
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            xs1_q  <= 1'b0;
            xs2_q  <= 1'b0;
            xs3_q  <= 1'b0;
            xlvl_q <= 1'b0;
        end else begin
            xs1_q <= xtal_clk_i;
            xs2_q <= xs1_q;
            xs3_q <= xs2_q;
            if (xs2_q == xs3_q) begin
                xlvl_q <= xs3_q;
            end
        end
    end

    // input clock choice
    // Crystal edges are only seen if no faster than a quarter of the bus clock
    assign in_tick = iclk_q ? 1'b1
                            : (xs2_q && xs3_q && !xlvl_q);

    // prescaler divide ratio
    // Free running, so the first tick lands at a fraction
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pre_cnt_q <= '0;
        end else if (in_tick) begin
            if ((pre_cnt_q & div_mask(div_q)) == div_mask(div_q)) begin
                pre_cnt_q <= '0;
            end else begin
                pre_cnt_q <= pre_cnt_q + 4'h1;
            end
        end
    end

    assign adc_tick = in_tick
        && ((pre_cnt_q & div_mask(div_q)) == div_mask(div_q));

    assign start_now = wr_sc
        && (bus_i.wdata[SC_CHAN_LSB +: CHAN_W] != CHAN_OFF);

    assign conv_done = (state_q == ST_CONV) && adc_tick
        && (tick_cnt_q == CNT_W'(CONV_TICKS - 1))
        && !wr_sc;

    // Conversion sequencer
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_q    <= ST_IDLE;
            tick_cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_now) begin
                        state_q    <= ST_CONV;
                        tick_cnt_q <= '0;
                    end
                end
                ST_CONV: begin
                    if (wr_sc) begin
                        state_q    <= start_now ? ST_CONV : ST_IDLE;
                        tick_cnt_q <= '0;
                    end else if (conv_done) begin
                        state_q    <= cont_q ? ST_CONV : ST_IDLE;
                        tick_cnt_q <= '0;
                    end else if (adc_tick) begin
                        tick_cnt_q <= tick_cnt_q + 5'h01;
                    end
                end
                default: begin
                    state_q    <= ST_IDLE;
                    tick_cnt_q <= '0;
                end
            endcase
        end
    end

    // Start pulse to the core, also on each continuous restart
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_now || (conv_done && cont_q);
        end
    end

    // Status/control fields
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ien_q  <= 1'b0;
            cont_q <= 1'b0;
            chan_q <= CHAN_RESET;
        end else if (wr_sc) begin
            ien_q  <= bus_i.wdata[SC_IEN_BIT];
            cont_q <= bus_i.wdata[SC_CONT_BIT];
            chan_q <= bus_i.wdata[SC_CHAN_LSB +: CHAN_W];
        end
    end

    // Continuous mode: only the first result sets done
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            first_q <= 1'b1;
        end else if (wr_sc) begin
            first_q <= 1'b1;
        end else if (conv_done) begin
            first_q <= 1'b0;
        end
    end

    // Done flag
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            done_q <= 1'b0;
        end else if (ien_q) begin
            if (wr_sc) begin
                done_q <= bus_i.wdata[SC_DONE_BIT];
            end
        end else if (conv_done && (!cont_q || first_q)) begin
            done_q <= 1'b1;
        end else if (wr_sc || rd_lo) begin
            done_q <= 1'b0;
        end
    end

    // held until an access clears it
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            irq_q <= 1'b0;
        end else if (conv_done && ien_q) begin
            irq_q <= 1'b1;
        end else if (wr_sc || rd_lo) begin
            irq_q <= 1'b0;
        end
    end

    // Clock config fields
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            div_q  <= DIV_RESET;
            iclk_q <= ICLK_RESET;
            fmt_q  <= FMT_RESET;
        end else if (wr_ck) begin
            div_q  <= bus_i.wdata[CK_DIV_LSB +: DIV_W];
            iclk_q <= bus_i.wdata[CK_ICLK_BIT];
            fmt_q  <= adcr_fmt_t'(bus_i.wdata[CK_MODE_LSB +: MODE_W]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            freeze_q <= 1'b0;
        end else if (rd_lo || !justified) begin
            freeze_q <= 1'b0;
        end else if (rd_hi) begin
            freeze_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            res_q <= '0;
        end else if (conv_done && !(freeze_q && justified)) begin
            res_q <= core_result_i;
        end
    end

    // Formatting of the stored result
    always_comb begin
        hi_fmt = '0;
        lo_fmt = '0;
        case (fmt_q)
            FMT_TRUNC8: begin
                lo_fmt = res_q[RES_W-1 -: DATA_W];
            end
            FMT_RIGHT: begin
                hi_fmt = {6'h00, res_q[RES_W-1 -: 2]};
                lo_fmt = res_q[DATA_W-1:0];
            end
            FMT_LEFT: begin
                hi_fmt = res_q[RES_W-1 -: DATA_W];
                lo_fmt = {res_q[1:0], 6'h00};
            end
            FMT_LEFT_SGN: begin
                hi_fmt = {~res_q[RES_W-1], res_q[RES_W-2 -: DATA_W-1]};
                lo_fmt = {res_q[1:0], 6'h00};
            end
            default: begin
                hi_fmt = '0;
                lo_fmt = '0;
            end
        endcase
    end

    // Low half captured at the high read for the interlock
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            low_hold_q <= '0;
        end else if (rd_hi && justified && !freeze_q) begin
            low_hold_q <= lo_fmt;
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux = '0;
        case (bus_i.addr)
            OFS_STATUS_CONTROL: begin
                rd_mux = {done_q, ien_q, cont_q, chan_q};
            end
            OFS_RESULT_HIGH: begin
                rd_mux = hi_fmt;
            end
            OFS_RESULT_LOW: begin
                rd_mux = (freeze_q && justified) ? low_hold_q : lo_fmt;
            end
            OFS_CLOCK_CONFIG: begin
                rd_mux = {div_q, iclk_q, fmt_q, 2'b00};
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= bus_i.rd ? rd_mux : '0;
        end
    end

    // flag the factory code; unused codes pass through
    assign factory_code_o   = (chan_q == CHAN_FACTORY);
    assign channel_select_o = chan_q;
    assign core_power_en_o  = (chan_q != CHAN_OFF);
    assign conv_start_o     = start_q;
    assign conv_busy_o      = (state_q == ST_CONV);
    assign adc_tick_o       = adc_tick && core_power_en_o;
    assign irq_o            = irq_q;
    assign rdata_o          = rdata_q;

endmodule

`default_nettype wire
